/* File: hdl/ppm_pkg.sv */
// package: constants for the port pin function multiplexer
package ppm_pkg;
  // ------------------------------------------------------------
  // configuration register layout
  // ------------------------------------------------------------
  localparam logic [7:0] PPM_CFG1_RESET   = 8'h00;
  localparam logic [7:0] PPM_CFG2_RESET   = 8'h00;
  localparam int         PPM_CFG2_SDA_BIT = 0;
  localparam int         PPM_CFG2_SCL_BIT = 1;
  localparam int         PPM_CFG2_VS_BIT  = 6;
  localparam int         PPM_CFG2_HS_BIT  = 7;
  localparam int         PPM_PC_PWM_BASE  = 8;
  // ------------------------------------------------------------
  // port widths
  // ------------------------------------------------------------
  localparam int         PPM_PA_W         = 8;
  localparam int         PPM_PB_W         = 6;
  localparam int         PPM_PC_W         = 8;
  localparam int         PPM_PD_W         = 2;
  localparam logic [7:0] PPM_DDR_RESET    = 8'h00;
  // ------------------------------------------------------------
  // external interrupt sensitivity
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PPM_IRQ_IDLE = 2'h1,
    PPM_IRQ_HELD = 2'h2
  } ppm_irq_st_t;
endpackage

/* File: hdl/ppm_sync3.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module ppm_sync3 #(
  parameter int W = 1
) (
  input  wire logic         mclk,    // core clock
  input  wire logic         arst_n,  // async reset, active low
  input  wire logic [W-1:0] pin_in,  // raw pin level
  output logic      [W-1:0] clean    // filtered level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } ppm_sync_st_t;
  ppm_sync_st_t st_reg;
  ppm_sync_st_t st_next;

  // a change counts only once stages two and three agree
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.q[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign clean = st_reg.q;
endmodule // ppm_sync3

/* File: hdl/ppm_port_mux.sv */
// port pin function multiplexer: ports A-D, configuration, irq, sync inputs
//
// Contract
// - reset makes ports A, B, C inputs
// - config1 bits route PC0-5 to pulse 8-13
// - config2 serial bits make PD open-drain bus
// - irq falling edge, or edge plus level
// - PC6/PC7 general, pulse or sync output
// - eight dedicated pulse pins, channels 0-7
// - low reset pin resets; start without it
// - sync inputs accepted in either polarity
// - sync select beats pulse select on PC6/7
// - both configuration registers reset to zero
// - alternate function ignores data-direction bit
`timescale 1ns/10ps
module ppm_port_mux (
  input  wire logic       mclk,          // core clock, 40 MHz
  input  wire logic       arst_n,        // async reset (power-on or pin), low
  // configuration writes from the core
  input  wire logic       cfg1_we,       // write strobe, pulse select register
  input  wire logic       cfg2_we,       // write strobe, sync/serial select register
  input  wire logic       ddr_we,        // write strobe, direction register picked by ddr_sel
  input  wire logic [1:0] ddr_sel,       // 0 A, 1 B, 2 C, 3 D
  input  wire logic [7:0] wdata,         // write data
  output logic      [7:0] cfg1_q,        // pulse select register readback
  output logic      [7:0] cfg2_q,        // sync/serial select readback
  output logic      [7:0] ddr_a_q,       // direction register A
  output logic      [5:0] ddr_b_q,       // direction register B
  output logic      [7:0] ddr_c_q,       // direction register C
  output logic      [1:0] ddr_d_q,       // direction register D
  // port data latches from the core
  input  wire logic [7:0] pa_dout,       // port A latch
  input  wire logic [5:0] pb_dout,       // port B latch
  input  wire logic [7:0] pc_dout,       // port C latch
  input  wire logic [1:0] pd_dout,       // port D latch
  // peripheral sources
  input  wire logic [15:0] pulse_ch,     // pulse-width channels 0-15
  input  wire logic       hsync_out,     // sync processor horizontal output
  input  wire logic       vsync_out,     // sync processor vertical output
  input  wire logic       ser_sda_lo,    // serial block pulls data low
  input  wire logic       ser_scl_lo,    // serial block pulls clock low
  output logic            ser_sda_in,    // synchronised serial data line
  output logic            ser_scl_in,    // synchronised serial clock line
  // pins (input / output / enable)
  input  wire logic [7:0] pa_in,         // port A pin level
  output logic      [7:0] pa_out,        // port A drive value
  output logic      [7:0] pa_oe,         // port A drive enable
  input  wire logic [5:0] pb_in,         // port B pin level
  output logic      [5:0] pb_out,        // port B drive value
  output logic      [5:0] pb_oe,         // port B drive enable
  input  wire logic [7:0] pc_in,         // port C pin level
  output logic      [7:0] pc_out,        // port C drive value
  output logic      [7:0] pc_oe,         // port C drive enable
  input  wire logic [1:0] pd_in,         // port D pin level
  output logic      [1:0] pd_out,        // port D drive value
  output logic      [1:0] pd_oe,         // port D drive enable
  output logic      [7:0] pulse_pin,     // dedicated pulse pins 0-7
  output logic      [7:0] pa_rd,         // port A read value
  output logic      [5:0] pb_rd,         // port B read value
  output logic      [7:0] pc_rd,         // port C read value
  output logic      [1:0] pd_rd,         // port D read value
  // external interrupt
  input  wire logic       irq_n_pin,     // interrupt pin, active low
  input  wire logic       irq_level_en,  // 1: edge and level, 0: edge only
  input  wire logic       irq_ack,       // core takes the interrupt
  output logic            irq_req,       // interrupt request to the core
  // sync inputs
  input  wire logic       hsync_pin,     // horizontal sync from host
  input  wire logic       vsync_pin,     // vertical sync from host
  output logic            hsync_raw,     // synchronised, polarity as received
  output logic            vsync_raw      // synchronised, polarity as received
);
  // ------------------------------------------------------------
  // registered state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  cfg1;
    logic [7:0]  cfg2;
    logic [7:0]  ddr_a;
    logic [5:0]  ddr_b;
    logic [7:0]  ddr_c;
    logic [1:0]  ddr_d;
    logic        irq_prev;
    logic        irq_pend;
    ppm_pkg::ppm_irq_st_t irq_st;
    logic [7:0]  pc_o;
    logic [7:0]  pc_e;
    logic [1:0]  pd_o;
    logic [1:0]  pd_e;
    logic [7:0]  pwm_o;
  } ppm_st_t;
  ppm_st_t st_reg;
  ppm_st_t st_next;

  logic [7:0] pa_s;
  logic [5:0] pb_s;
  logic [7:0] pc_s;
  logic [1:0] pd_s;
  logic       irq_lo_s;  // filtered interrupt pin, high while the pin is low
  logic       hs_s;
  logic       vs_s;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // interrupt pin enters inverted: the filter resets to 0, which then equals the idle pin
  ppm_sync3 #(.W(27)) u_sync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .pin_in ({pa_in, pb_in, pc_in, pd_in, ~irq_n_pin, hsync_pin, vsync_pin}),
    .clean  ({pa_s, pb_s, pc_s, pd_s, irq_lo_s, hs_s, vs_s})
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic fall;
    fall    = ~st_reg.irq_prev & irq_lo_s;
    st_next = st_reg;
    if (cfg1_we) begin
      st_next.cfg1 = wdata;
    end
    if (cfg2_we) begin
      st_next.cfg2 = wdata;
    end
    if (ddr_we) begin
      unique case (ddr_sel)
        2'h0: st_next.ddr_a = wdata;
        2'h1: st_next.ddr_b = wdata[5:0];
        2'h2: st_next.ddr_c = wdata;
        2'h3: st_next.ddr_d = wdata[1:0];
      endcase
    end
    // port C: alternate function wins over the direction bit
    for (int i = 0; i < 6; i++) begin
      st_next.pc_e[i] = st_reg.cfg1[i] | st_reg.ddr_c[i];
      st_next.pc_o[i] = st_reg.cfg1[i] ? pulse_ch[ppm_pkg::PPM_PC_PWM_BASE + i]
                                       : pc_dout[i];
    end
    // PC6 vertical, PC7 horizontal; sync select overrides pulse select
    if (st_reg.cfg2[ppm_pkg::PPM_CFG2_VS_BIT]) begin
      st_next.pc_o[6] = vsync_out;
      st_next.pc_e[6] = 1'b1;
    end else if (st_reg.cfg1[6]) begin
      st_next.pc_o[6] = pulse_ch[14];
      st_next.pc_e[6] = 1'b1;
    end else begin
      st_next.pc_o[6] = pc_dout[6];
      st_next.pc_e[6] = st_reg.ddr_c[6];
    end
    if (st_reg.cfg2[ppm_pkg::PPM_CFG2_HS_BIT]) begin
      st_next.pc_o[7] = hsync_out;
      st_next.pc_e[7] = 1'b1;
    end else if (st_reg.cfg1[7]) begin
      st_next.pc_o[7] = pulse_ch[15];
      st_next.pc_e[7] = 1'b1;
    end else begin
      st_next.pc_o[7] = pc_dout[7];
      st_next.pc_e[7] = st_reg.ddr_c[7];
    end
    // port D: serial use drives only low, released otherwise (open drain)
    if (st_reg.cfg2[ppm_pkg::PPM_CFG2_SDA_BIT]) begin
      st_next.pd_o[0] = 1'b0;
      st_next.pd_e[0] = ser_sda_lo;
    end else begin
      st_next.pd_o[0] = pd_dout[0];
      st_next.pd_e[0] = st_reg.ddr_d[0];
    end
    if (st_reg.cfg2[ppm_pkg::PPM_CFG2_SCL_BIT]) begin
      st_next.pd_o[1] = 1'b0;
      st_next.pd_e[1] = ser_scl_lo;
    end else begin
      st_next.pd_o[1] = pd_dout[1];
      st_next.pd_e[1] = st_reg.ddr_d[1];
    end
    st_next.pwm_o = pulse_ch[7:0];
    // external interrupt: a new edge beats a same-cycle acknowledge
    st_next.irq_prev = irq_lo_s;
    if (irq_ack) begin
      st_next.irq_pend = 1'b0;
    end
    if (fall && st_reg.irq_st == ppm_pkg::PPM_IRQ_IDLE) begin
      st_next.irq_pend = 1'b1;
    end
    unique case (st_reg.irq_st)
      ppm_pkg::PPM_IRQ_IDLE: if (fall) st_next.irq_st = ppm_pkg::PPM_IRQ_HELD;
      ppm_pkg::PPM_IRQ_HELD: if (!irq_lo_s) st_next.irq_st = ppm_pkg::PPM_IRQ_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // registers; reset makes all ports inputs, shared pins plain I/O
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg          <= '0;
      st_reg.cfg1     <= ppm_pkg::PPM_CFG1_RESET;
      st_reg.cfg2     <= ppm_pkg::PPM_CFG2_RESET;
      st_reg.ddr_a    <= ppm_pkg::PPM_DDR_RESET;
      st_reg.ddr_c    <= ppm_pkg::PPM_DDR_RESET;
      st_reg.irq_prev <= 1'b0;  // idle level, so release makes no false edge
      st_reg.irq_st   <= ppm_pkg::PPM_IRQ_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign cfg1_q    = st_reg.cfg1;
  assign cfg2_q    = st_reg.cfg2;
  assign ddr_a_q   = st_reg.ddr_a;
  assign ddr_b_q   = st_reg.ddr_b;
  assign ddr_c_q   = st_reg.ddr_c;
  assign ddr_d_q   = st_reg.ddr_d;
  assign pa_out    = pa_dout;
  assign pa_oe     = st_reg.ddr_a;
  assign pb_out    = pb_dout;
  assign pb_oe     = st_reg.ddr_b;
  assign pc_out    = st_reg.pc_o;
  assign pc_oe     = st_reg.pc_e;
  assign pd_out    = st_reg.pd_o;
  assign pd_oe     = st_reg.pd_e;
  assign pulse_pin = st_reg.pwm_o;
  // outputs read back their latch, inputs read the pin
  assign pa_rd     = (st_reg.ddr_a & pa_dout) | (~st_reg.ddr_a & pa_s);
  assign pb_rd     = (st_reg.ddr_b & pb_dout) | (~st_reg.ddr_b & pb_s);
  assign pc_rd     = (st_reg.ddr_c & pc_dout) | (~st_reg.ddr_c & pc_s);
  assign pd_rd     = (st_reg.ddr_d & pd_dout) | (~st_reg.ddr_d & pd_s);
  assign ser_sda_in = pd_s[0];
  assign ser_scl_in = pd_s[1];
  // level mode keeps requesting while the pin stays low
  assign irq_req   = st_reg.irq_pend | (irq_level_en & irq_lo_s);
  // polarity is left to the sync processor, both senses pass unchanged
  assign hsync_raw = hs_s;
  assign vsync_raw = vs_s;
endmodule // ppm_port_mux

/* File: verif/ppm_port_mux_asserts.sv */
// checker: output relations of the port pin function multiplexer
`timescale 1ns/10ps
module ppm_port_mux_asserts (
  input logic        mclk,       // core clock
  input logic        arst_n,     // async reset, low
  input logic [7:0]  cfg1_q,     // pulse select
  input logic [7:0]  cfg2_q,     // sync and serial select
  input logic [7:0]  pa_oe,      // port A enable
  input logic [7:0]  pc_oe,      // port C enable
  input logic [7:0]  pc_out,     // port C value
  input logic [1:0]  pd_oe,      // port D enable
  input logic [1:0]  pd_out,     // port D value
  input logic [15:0] pulse_ch,   // pulse channels
  input logic        hsync_out,  // horizontal sync source
  input logic        vsync_out,  // vertical sync source
  input logic        ser_sda_lo, // serial data pull
  input logic [7:0]  pulse_pin,  // dedicated pulse pins
  input logic        irq_n_pin,  // interrupt pin
  input logic        irq_ack,    // interrupt taken
  input logic        irq_req     // interrupt request
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_irq_fall;
    $fell(irq_n_pin) && !irq_ack;
  endsequence
  // pin filter plus pending flop make the request lag the pin
  sequence s_irq_seen;
    ##[1:8] irq_req;
  endsequence
  property p_pc_pulse;
    |cfg1_q[5:0] |=> (pc_oe[5:0] & $past(cfg1_q[5:0])) == $past(cfg1_q[5:0]) &&
      ((pc_out[5:0] ^ $past(pulse_ch[13:8])) & $past(cfg1_q[5:0])) == 6'h00;
  endproperty
  reset_dir_a: assert property ($rose(arst_n) |-> !{pa_oe, pc_oe, cfg1_q, cfg2_q})
    else $error("port driven or select set after reset");
  pc_pulse_a: assert property (p_pc_pulse)
    else $error("low port C bits not carrying pulse channels");
  pc7_sync_a: assert property (cfg2_q[7] |=> pc_oe[7] && pc_out[7] == $past(hsync_out))
    else $error("horizontal sync not on port C bit 7");
  pc6_sync_a: assert property (cfg2_q[6] |=> pc_oe[6] && pc_out[6] == $past(vsync_out))
    else $error("vertical sync not on port C bit 6");
  pc7_pulse_a: assert property (cfg1_q[7] && !cfg2_q[7] |=> pc_out[7] == $past(pulse_ch[15]))
    else $error("pulse channel 15 not on port C bit 7");
  serial_od_a: assert property (cfg2_q[0] |=> !pd_out[0] && pd_oe[0] == $past(ser_sda_lo))
    else $error("serial data pin not open drain");
  pulse_pin_a: assert property (arst_n |=> pulse_pin == $past(pulse_ch[7:0]))
    else $error("dedicated pulse pins mismatch");
  irq_edge_a: assert property (s_irq_fall |-> s_irq_seen)
    else $error("falling interrupt pin gave no request");
endmodule // ppm_port_mux_asserts
bind ppm_port_mux ppm_port_mux_asserts u_chk (.*);

/* File: verif/ppm_pin_model.sv */
// model: board wiring seen by the shared port pins
`timescale 1ns/10ps
module ppm_pin_model (
  input  logic [7:0]  pa_out, // device value, port A
  input  logic [7:0]  pa_oe,  // device enable, port A
  input  logic [5:0]  pb_out, // device value, port B
  input  logic [5:0]  pb_oe,  // device enable, port B
  input  logic [7:0]  pc_out, // device value, port C
  input  logic [7:0]  pc_oe,  // device enable, port C
  input  logic [1:0]  pd_out, // device value, port D
  input  logic [1:0]  pd_oe,  // device enable, port D
  input  logic [21:0] ext,    // other circuits on A, B, C
  input  logic [1:0]  ext_lo, // other bus parties pulling low
  output logic [7:0]  pa_in,  // level, port A
  output logic [5:0]  pb_in,  // level, port B
  output logic [7:0]  pc_in,  // level, port C
  output logic [1:0]  pd_in   // level, port D
);
  // an undriven pin shows the board's level, which the bench changes every test
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext[7:0]);
  assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext[13:8]);
  assign pc_in = (pc_oe & pc_out) | (~pc_oe & ext[21:14]);
  // wired-and with a pull-up, so a released line reads high
  assign pd_in = ~((pd_oe & ~pd_out) | ext_lo);
endmodule // ppm_pin_model

/* File: verif/port_pin_function_mux_tb_top.sv */
// testbench: random configuration of the port pin function multiplexer
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module port_pin_function_mux_tb_top;
  logic        mclk = 1'b0, arst_n = 1'b0, cfg1_we = 1'b0, cfg2_we = 1'b0, ddr_we = 1'b0;
  logic        irq_ack = 1'b0, irq_n_pin = 1'b1, irq_level_en = 1'b0, hsync_pin = 1'b0;
  logic        vsync_pin = 1'b0, hsync_out = 1'b0, vsync_out = 1'b0, ser_sda_lo = 1'b0;
  logic        ser_scl_lo = 1'b0, ser_sda_in, ser_scl_in, irq_req, hsync_raw, vsync_raw;
  logic [1:0]  ddr_sel = 2'h0, pd_dout = 2'h0, ext_lo = 2'h0, ddr_d_q, pd_in, pd_out, pd_oe;
  logic [1:0]  pd_rd, lvl;
  logic [5:0]  pb_dout = 6'h00, ddr_b_q, pb_in, pb_out, pb_oe, pb_rd;
  logic [7:0]  wdata = 8'h00, pa_dout = 8'h00, pc_dout = 8'h00, cfg1_q, cfg2_q, ddr_a_q;
  logic [7:0]  ddr_c_q, pa_in, pa_out, pa_oe, pc_in, pc_out, pc_oe, pa_rd, pc_rd, pulse_pin;
  logic [7:0]  c1, c2, dd [4];
  logic [15:0] pulse_ch = 16'h0000, ep;
  logic [21:0] ext = 22'h0;
  logic [31:0] seed = 32'h299CF0DE, r;
  logic [3:0]  ed;
  int          fails = 0, tests_run = 0;
  always #12.5 mclk = ~mclk;
  ppm_port_mux dut (.*);
  ppm_pin_model board (.*);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // sync select outranks the pulse select on the top two bits
  function automatic logic [15:0] exp_pc(logic [7:0] a, b, d, q, logic [15:0] p, logic h, v);
    logic [7:0] oe, o;
    for (int i = 0; i < 8; i++) begin
      oe[i] = a[i] | d[i] | (i > 5 && b[i]);
      o[i] = (i > 5 && b[i]) ? ((i == 7) ? h : v) : a[i] ? p[ppm_pkg::PPM_PC_PWM_BASE + i] : q[i];
    end
    return {oe, o};
  endfunction
  function automatic logic [3:0] exp_pd(logic [1:0] b, d, q, lo);
    return {(b & lo) | (~b & d), ~b & q};
  endfunction
  task automatic wr(input logic [1:0] k, s, input logic [7:0] d);
    @(posedge mclk);
    {cfg1_we, cfg2_we, ddr_we} <= {k == 2'h0, k == 2'h1, k == 2'h2};
    {ddr_sel, wdata} <= {s, d};
    @(posedge mclk);
    {cfg1_we, cfg2_we, ddr_we} <= 3'h0;
  endtask
  task automatic do_reset();
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    #1;
    `CHK("cfg", {ppm_pkg::PPM_CFG1_RESET, ppm_pkg::PPM_CFG2_RESET}, {cfg1_q, cfg2_q})
    `CHK("dir", 24'h0, {ddr_a_q, ddr_b_q, ddr_c_q, ddr_d_q})
    `CHK("oe", 24'h0, {pa_oe, pb_oe, pc_oe, pd_oe})
    repeat (6) @(posedge mclk);
    #1;
    `CHK("irq after reset", 1'b0, irq_req)
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #150000;
    fails++;
    $display("watchdog expired");
    finish_test();
  end
  initial begin
    do_reset();
    $display("reset test done");
    @(posedge mclk);
    irq_n_pin <= 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    `CHK("irq edge", 1'b1, irq_req)
    for (int m = 0; m < 2; m++) begin
      @(posedge mclk);
      {irq_ack, irq_level_en} <= {1'b1, m[0]};
      @(posedge mclk);
      irq_ack <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      `CHK("irq held low", m[0], irq_req)
    end
    @(posedge mclk);
    irq_n_pin <= 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    `CHK("irq released", 1'b0, irq_req)
    $display("interrupt test done");
    for (int n = 0; n < 40; n++) begin
      c1 = (n == 0) ? 8'hFF : (n == 1) ? 8'hC0 : 8'(rnd());
      c2 = (n == 0) ? 8'hC3 : (n == 1) ? 8'h00 : 8'(rnd());
      for (int s = 0; s < 4; s++) begin
        dd[s] = (n == 0) ? 8'h00 : 8'(rnd());
        wr(2'h2, 2'(s), dd[s]);
      end
      wr(2'h0, 2'h0, c1);
      wr(2'h1, 2'h0, c2);
      r = rnd();
      {pc_dout, pa_dout, pulse_ch} <= r;
      r = rnd();
      {ext_lo, hsync_pin, vsync_pin, pb_dout} <= r[9:0];
      {pd_dout, hsync_out, vsync_out, ser_sda_lo, ser_scl_lo} <= r[15:10];
      ext <= 22'(rnd());
      repeat (8) @(posedge mclk);
      #1;
      ep = exp_pc(c1, c2, dd[2], pc_dout, pulse_ch, hsync_out, vsync_out);
      `CHK("port C", ep, {pc_oe, pc_out})
      ed = exp_pd(c2[1:0], dd[3][1:0], pd_dout, {ser_scl_lo, ser_sda_lo});
      `CHK("port D", ed, {pd_oe, pd_out})
      lvl = ~((ed[3:2] & ~ed[1:0]) | ext_lo);
      `CHK("bus lines", lvl, {ser_scl_in, ser_sda_in})
      `CHK("dir", {dd[0], dd[1][5:0], dd[3][1:0]}, {pa_oe, pb_oe, ddr_d_q})
      `CHK("port A read", (dd[0] & pa_dout) | (~dd[0] & ext[7:0]), pa_rd)
      `CHK("port B read", (dd[1][5:0] & pb_dout) | (~dd[1][5:0] & ext[13:8]), pb_rd)
      `CHK("port C read", (dd[2] & pc_dout) | (~dd[2] & ((ep[15:8] & ep[7:0]) | (~ep[15:8] & ext[21:14]))), pc_rd)
      `CHK("port D read", (dd[3][1:0] & pd_dout) | (~dd[3][1:0] & lvl), pd_rd)
      `CHK("config", {c1, c2, dd[2]}, {cfg1_q, cfg2_q, ddr_c_q})
      `CHK("latch out", {pa_dout, pb_dout}, {pa_out, pb_out})
      `CHK("pulse pins", pulse_ch[7:0], pulse_pin)
      `CHK("sync in", {hsync_pin, vsync_pin}, {hsync_raw, vsync_raw})
    end
    $display("mux test done");
    do_reset();
    $display("second reset test done");
    finish_test();
  end
endmodule // port_pin_function_mux_tb_top
